// File: rtl/irq_handler_map.vh
// register offsets, field positions, reset values and timing for the interrupt handler
`ifndef IRQ_HANDLER_MAP_VH
`define IRQ_HANDLER_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_ENABLE        8'h00
`define OFS_PRIORITY      8'h04
`define OFS_PENDING       8'h08
`define OFS_PEND_CLEAR    8'h0C
`define OFS_STATUS        8'h10
`define OFS_IRQ_STATUS    8'h14
`define OFS_IRQ_CLEAR     8'h18
`define OFS_IRQ_ENABLE    8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define GLOBAL_EN_BIT     7
`define HW_CLEAR_MASK     8'h0F
`define SRC_COUNT         8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_ENABLE        8'h00
`define RST_PRIORITY      8'h00
`define RST_PENDING       8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CALL_CYCLES       3'h4

// ----------------------------------------
// axi responses
// ----------------------------------------
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// File: rtl/vector_rom.v
// small lookup memory: source index to service address, registered read data
module vector_rom
(
   // clock
   input  wire        core_clk,
   // lookup
   input  wire [2:0]  index,
   output reg  [15:0] address
);

   always @(posedge core_clk)
   begin
      case (index)
         3'h0:    address <= 16'h0003;
         3'h1:    address <= 16'h000B;
         3'h2:    address <= 16'h0013;
         3'h3:    address <= 16'h001B;
         3'h4:    address <= 16'h0023;
         3'h5:    address <= 16'h002B;
         3'h6:    address <= 16'h0043;
         3'h7:    address <= 16'h007B;
         default: address <= 16'h0000;
      endcase
   end

endmodule // vector_rom

// File: rtl/cpu_interrupt_handler.v
// vectored interrupt handler with two priority levels and an AXI4-Lite register file
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`include "irq_handler_map.vh"
module cpu_interrupt_handler
#(
   parameter N_SRC = `SRC_COUNT
)
(
   // clock and reset
   input  wire              core_clk,
   input  wire              rst_n,
   // interrupt sources
   input  wire [N_SRC-1:0]  src_event,
   input  wire              usb_function_source,
   // cpu sequencer
   input  wire              instr_done,
   input  wire              next_multi_cycle,
   input  wire              return_from_irq,
   input  wire              clear_global_enable_instr,
   output reg               long_vector_call,
   output reg  [15:0]       vector_addr,
   output reg               in_service,
   // interrupt line
   output reg               irq,
   // axi4-lite slave
   input  wire [7:0]        s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [7:0]        s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_LOOK = 2'b01;
   localparam ST_CALL = 2'b10;

   reg  [7:0]  irq_enable_reg;      // bit 7 global_irq_enable
   reg  [7:0]  prio_level;
   reg  [7:0]  pending;
   reg  [1:0]  state;
   reg  [2:0]  call_cnt;
   reg  [2:0]  sel;
   reg         sel_high;
   reg         high_active;
   reg         low_active;
   reg         armed;               // request seen before instruction end
   reg         ge_late;             // enable as seen before a clear instruction
   reg  [2:0]  irq_status;
   reg  [2:0]  irq_en;
   reg  [7:0]  aw_addr;
   reg         aw_held;
   reg  [31:0] w_data;
   reg         w_held;
   reg  [7:0]  src_s1;
   reg  [7:0]  src_s2;
   reg  [7:0]  src_s3;
   reg         usb_s1;
   reg         usb_s2;
   wire [15:0] rom_addr;

   // ----------------------------------------
   // priority pick
   // ----------------------------------------
   function [3:0] pick;
      input [7:0] req;
      integer     i;
      begin
         pick = 4'h0;
         for (i = 7; i >= 0; i = i - 1)
            if (req[i])
               pick = {1'b1, i[2:0]};     // lowest index wins
      end
   endfunction

   wire [7:0] flags     = {pending[7], usb_s2, pending[5:0]};
   wire       ge_eff    = irq_enable_reg[`GLOBAL_EN_BIT] | ge_late;
   wire [7:0] req       = flags & irq_enable_reg & {8{ge_eff}};
   wire [3:0] hi_pick   = pick(req & prio_level);
   wire [3:0] lo_pick   = pick(req & ~prio_level);
   // high always over low; low only with nothing in service
   wire       can_high  = !high_active;
   wire       can_low   = !high_active && !low_active;
   wire       take_high = hi_pick[3] && can_high;
   wire       take_low  = lo_pick[3] && can_low && !take_high;
   wire [2:0] next_sel  = take_high ? hi_pick[2:0] : lo_pick[2:0];
   wire       rq        = take_high || take_low;

   vector_rom vector_rom_i
   (
      .core_clk (core_clk),
      .index    (sel),
      .address  (rom_addr)
   );

   // ----------------------------------------
   // source synchronisers
   // ----------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_s1 <= 8'h00;
         src_s2 <= 8'h00;
         src_s3 <= 8'h00;
         usb_s1 <= 1'b0;
         usb_s2 <= 1'b0;
      end
      else
      begin
         src_s1 <= src_event;
         src_s2 <= src_s1;
         src_s3 <= src_s2;
         usb_s1 <= usb_function_source;
         usb_s2 <= usb_s1;
      end
   end

   wire [7:0] src_rise = src_s2 & ~src_s3;

   // ----------------------------------------
   // axi write side
   // ----------------------------------------
   wire        wr_go   = aw_held && w_held && !s_axi_bvalid;
   wire [7:0]  wbyte   = w_data[7:0];
   wire        wr_en   = wr_go && aw_addr == `OFS_ENABLE;
   wire        wr_pri  = wr_go && aw_addr == `OFS_PRIORITY;
   wire        wr_pend = wr_go && aw_addr == `OFS_PENDING;
   wire        wr_pclr = wr_go && aw_addr == `OFS_PEND_CLEAR;
   wire        wr_iclr = wr_go && aw_addr == `OFS_IRQ_CLEAR;
   wire        wr_ien  = wr_go && aw_addr == `OFS_IRQ_ENABLE;
   wire        wr_map  = wr_en | wr_pri | wr_pend | wr_pclr | wr_iclr | wr_ien;
   wire        vec_go  = state == ST_CALL && call_cnt == 3'h1;
   wire        ret_go  = return_from_irq && (high_active || low_active);

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr       <= s_axi_awaddr;
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data       <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // control registers and pending flags
   // ----------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_enable_reg <= `RST_ENABLE;
         prio_level     <= `RST_PRIORITY;
         pending        <= `RST_PENDING;
         irq_en         <= 3'h0;
      end
      else
      begin
         if (wr_en)
            irq_enable_reg <= wbyte;
         else if (clear_global_enable_instr)
            irq_enable_reg[`GLOBAL_EN_BIT] <= 1'b0;
         if (wr_pri)
            prio_level <= wbyte;
         if (wr_ien)
            irq_en <= wbyte[2:0];
         // events win over software and vector clears
         pending <= ((pending
                      & ~(wr_pclr ? wbyte : 8'h00)
                      & ~(vec_go ? (`HW_CLEAR_MASK & (8'h01 << sel)) : 8'h00))
                     | (wr_pend ? wbyte : 8'h00)
                     | src_rise) & 8'hBF;
      end
   end

   // ----------------------------------------
   // sequencing of the call
   // ----------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state            <= ST_IDLE;
         call_cnt         <= 3'h0;
         sel              <= 3'h0;
         sel_high         <= 1'b0;
         high_active      <= 1'b0;
         low_active       <= 1'b0;
         armed            <= 1'b0;
         ge_late          <= 1'b0;
         long_vector_call <= 1'b0;
         vector_addr      <= 16'h0000;
         in_service       <= 1'b0;
      end
      else
      begin
         long_vector_call <= 1'b0;
         // request posted while enable is being cleared survives one-cycle follower
         // grace lasts exactly one single-cycle follower, none for a multi-cycle one
         if (clear_global_enable_instr)
            ge_late <= irq_enable_reg[`GLOBAL_EN_BIT] && !next_multi_cycle;
         else if (instr_done)
            ge_late <= 1'b0;
         if (ret_go)
         begin
            // high routine returns first since low cannot run over it
            if (high_active)
               high_active <= 1'b0;
            else
               low_active <= 1'b0;
         end
         case (state)
            ST_IDLE:
            begin
               if (rq)
               begin
                  sel      <= next_sel;
                  sel_high <= take_high;
                  armed    <= 1'b1;
                  state    <= ST_LOOK;
               end
            end
            ST_LOOK:
            begin
               if (!rq)
               begin
                  armed <= 1'b0;
                  state <= ST_IDLE;
               end
               // not on the return itself: the follower's end takes the call
               else if (instr_done && !ret_go)
               begin
                  sel      <= next_sel;
                  sel_high <= take_high;
                  ge_late  <= 1'b0;
                  call_cnt <= `CALL_CYCLES;
                  state    <= ST_CALL;
               end
               else
               begin
                  sel      <= next_sel;
                  sel_high <= take_high;
               end
            end
            ST_CALL:
            begin
               call_cnt <= call_cnt - 3'h1;
               if (call_cnt == 3'h1)
               begin
                  long_vector_call <= 1'b1;
                  vector_addr      <= rom_addr;
                  armed            <= 1'b0;
                  if (sel_high)
                     high_active <= 1'b1;
                  else
                     low_active <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
         in_service <= high_active | low_active;
      end
   end

   // ----------------------------------------
   // handler events and interrupt line
   // ----------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_status <= 3'h0;
         irq        <= 1'b0;
      end
      else
      begin
         // set beats clear
         irq_status <= (irq_status & ~(wr_iclr ? wbyte[2:0] : 3'h0))
                       | {ret_go, vec_go && sel_high, vec_go};
         irq        <= |(irq_status & irq_en);
      end
   end

   // ----------------------------------------
   // axi read side
   // ----------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            case (s_axi_araddr)
               `OFS_ENABLE:     s_axi_rdata <= {24'h000000, irq_enable_reg};
               `OFS_PRIORITY:   s_axi_rdata <= {24'h000000, prio_level};
               `OFS_PENDING:    s_axi_rdata <= {24'h000000, flags};
               `OFS_STATUS:     s_axi_rdata <= {24'h000000, high_active, low_active,
                                                armed, 2'b00, sel};
               `OFS_IRQ_STATUS: s_axi_rdata <= {29'h0000000, irq_status};
               `OFS_IRQ_ENABLE: s_axi_rdata <= {29'h0000000, irq_en};
               `OFS_PEND_CLEAR,
               `OFS_IRQ_CLEAR:  s_axi_rdata <= 32'h0000_0000;
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // cpu_interrupt_handler

// File: tb/irq_handler_checker.sv
// port assertions for the interrupt handler
`include "irq_handler_map.vh"
module irq_handler_checker
(
   // clock and reset
   input logic        core_clk,
   input logic        rst_n,
   // cpu link
   input logic        instr_done,
   input logic        long_vector_call,
   input logic [15:0] vector_addr,
   input logic        in_service,
   // register bus
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic [7:0]  s_axi_araddr,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   call_pulse_a: assert property (long_vector_call |=> !long_vector_call)
      else $error("vector call wider than one cycle");
   call_delay_a: assert property (long_vector_call |-> $past(instr_done, 5))
      else $error("vector call not five cycles after instruction end");
   vec_hold_a: assert property ($changed(vector_addr) |-> long_vector_call)
      else $error("vector moved without a call");
   vec_table_a: assert property (long_vector_call |-> vector_addr inside
      {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h0043, 16'h007B})
      else $error("vector outside the table");
   serv_level_a: assert property (long_vector_call |-> ##[0:1] in_service)
      else $error("call without routine active");
   wr_resp_a: assert property (wr_take_s |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   wr_busy_a: assert property (wr_take_s |=> !s_axi_awready && !s_axi_wready)
      else $error("write readies high while busy");
   rd_resp_a: assert property (rd_take_s |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   rd_err_a: assert property (rd_take_s and s_axi_araddr > 8'h1C |-> ##[1:2]
      (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0))
      else $error("unmapped read not refused");
endmodule // irq_handler_checker

bind cpu_interrupt_handler irq_handler_checker irq_handler_checker_i (.*);

// File: tb/cpu_seq_model.sv
// behavioural cpu sequencer facing the interrupt handler
module cpu_seq_model
(
   // clock and reset
   input  logic core_clk,
   input  logic rst_n,
   // bench control
   input  logic slow,
   input  logic clr_cmd,
   // handler link
   input  logic long_vector_call,
   output logic instr_done,
   output logic next_multi_cycle,
   output logic return_from_irq,
   output logic clear_global_enable_instr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   logic [2:0] step;
   logic [3:0] depth;
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {cnt, step, depth} <= '0;
         {instr_done, next_multi_cycle} <= 2'h0;
         {return_from_irq, clear_global_enable_instr} <= 2'h0;
      end
      else
      begin
         instr_done <= 1'b0;
         return_from_irq <= 1'b0;
         clear_global_enable_instr <= 1'b0;
         cnt <= cnt + 2'h1;
         if (long_vector_call)
         begin
            depth <= depth + 4'h1;
            step <= 3'h0;
            cnt <= 2'h0;
         end
         else if (cnt == {slow, 1'b1})
         begin
            // slow mode stretches every instruction to four cycles
            cnt <= 2'h0;
            instr_done <= 1'b1;
            clear_global_enable_instr <= clr_cmd;
            next_multi_cycle <= clr_cmd;
            step <= step + 3'h1;
            if (depth != 4'h0 && step == 3'h5)
            begin
               return_from_irq <= 1'b1;
               depth <= depth - 4'h1;
               step <= 3'h0;
            end
         end
      end
   end
endmodule // cpu_seq_model

// File: tb/tb_cpu_interrupt_handler.sv
// self-checking bench for the interrupt handler
`include "irq_handler_map.vh"
module tb_cpu_interrupt_handler;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rst_n, usb_function_source, slow, clr_cmd, irq, in_service;
   logic        instr_done, next_multi_cycle, return_from_irq, clear_global_enable_instr;
   logic        long_vector_call, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  src_event, s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [15:0] vector_addr, last_vec;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   int          bad_count, compares, calls, rets, cyc, c, i;
   logic [15:0] vec [7] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
                            16'h0043};

   cpu_interrupt_handler cpu_interrupt_handler_i (.*);
   cpu_seq_model cpu_seq_model_i (.*);

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic stop_test;
      $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // bounded wait for the call count to reach a figure
   task automatic wait_calls(input int want);
      for (int n = 0; n < 300 && calls < want; n++)
         @(posedge core_clk);
      chk(calls, want);
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (long_vector_call === 1'b1)
      begin
         calls++;
         last_vec = vector_addr;
      end
      if (return_from_irq === 1'b1)
         rets++;
      if (cyc > 20000)
      begin
         bad_count++;
         stop_test;
      end
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial
   begin
      {rst_n, usb_function_source, slow, clr_cmd, src_event} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`OFS_ENABLE);
      chk(d, 32'h0);
      rd(8'h20);
      chk(r, `RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h20, 32'h0);
      chk(r, `RESP_SLVERR);
      $display("test done: reset and refusal");
      // source enabled but global enable low
      wr(`OFS_ENABLE, 32'h10);
      chk(r, `RESP_OKAY);
      src_event <= 8'h10;
      repeat (8) @(posedge core_clk);
      src_event <= 8'h00;
      repeat (40) @(posedge core_clk);
      chk(calls, 0);
      rd(`OFS_PENDING);
      chk(d, 32'h10);
      wr(`OFS_ENABLE, 32'h90);
      wait_calls(1);
      chk(last_vec, 16'h0023);
      wait_calls(2);
      wr(`OFS_PEND_CLEAR, 32'h10);
      repeat (60) @(posedge core_clk);
      rd(`OFS_PENDING);
      chk(d, 32'h0);
      rd(`OFS_IRQ_STATUS);
      chk(d & 32'h5, 32'h5);
      wr(`OFS_IRQ_ENABLE, 32'h1);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'b1);
      wr(`OFS_IRQ_CLEAR, 32'h7);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'b0);
      $display("test done: enables and re-entry");
      // sources 0 to 5 through software set, usb by its level; source 7 is not driven
      wr(`OFS_ENABLE, 32'hFF);
      for (i = 0; i < 7; i++)
      begin
         c = calls;
         slow <= i[0];
         if (i == 6)
            usb_function_source <= 1'b1;
         else
            wr(`OFS_PENDING, 32'h1 << i);
         wait_calls(c + 1);
         chk(last_vec, vec[i]);
         rd(`OFS_PENDING);
         if (i < 4)
            chk(d & (32'h1 << i), 32'h0);
         else if (i == 6)
            usb_function_source <= 1'b0;
         else
            wr(`OFS_PEND_CLEAR, 32'h1 << i);
         repeat (60) @(posedge core_clk);
      end
      $display("test done: vector table");
      // same-cycle arbitration, high then fixed order
      for (i = 0; i < 2; i++)
      begin
         c = calls;
         wr(`OFS_PRIORITY, i ? 32'h0 : 32'h8);
         wr(`OFS_PENDING, i ? 32'h6 : 32'hA);
         wait_calls(c + 1);
         chk(last_vec, i ? 16'h000B : 16'h001B);
         wait_calls(c + 2);
         chk(last_vec, i ? 16'h0013 : 16'h000B);
         repeat (60) @(posedge core_clk);
      end
      // high request preempts a running low routine
      slow <= 1'b1;
      c = calls;
      wr(`OFS_PRIORITY, 32'h1);
      wr(`OFS_PENDING, 32'h10);
      wait_calls(c + 1);
      i = rets;
      wr(`OFS_PENDING, 32'h1);
      wait_calls(c + 2);
      chk(last_vec, 16'h0003);
      chk(rets, i);
      rd(`OFS_STATUS);
      chk(d, 32'hC0);
      wr(`OFS_PEND_CLEAR, 32'h10);
      repeat (80) @(posedge core_clk);
      $display("test done: priority");
      // clearing instruction drops global enable
      clr_cmd <= 1'b1;
      repeat (10) @(posedge core_clk);
      clr_cmd <= 1'b0;
      rd(`OFS_ENABLE);
      chk(d & 32'h80, 32'h0);
      c = calls;
      wr(`OFS_PENDING, 32'h10);
      repeat (60) @(posedge core_clk);
      chk(calls, c);
      $display("test done: global clear");
      stop_test;
   end
endmodule // tb_cpu_interrupt_handler
